// file: hdl/rvip_buf.sv
// Two-entry pixel buffer, output held in a register
`timescale 1ns/1ps
module rvip_buf
   import rvip_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic reset_in,
   rvip_px_if.snk    in_if,
   rvip_px_if.src    out_if
);

   logic [WORD_W-1:0] head_q;
   logic [WORD_W-1:0] tail_q;
   logic              head_vld_q;
   logic              tail_vld_q;
   logic              push;
   logic              pop;

   // Handshake terms
   assign push = in_if.valid & in_if.ready;
   assign pop = head_vld_q & out_if.ready;
   assign in_if.ready = ~tail_vld_q;
   assign out_if.valid = head_vld_q;
   assign out_if.data = head_q;

   // Entry movement
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         head_q <= '0;
         tail_q <= '0;
         head_vld_q <= 1'b0;
         tail_vld_q <= 1'b0;
      end
      else if (pop && tail_vld_q)
      begin
         head_q <= tail_q;
         tail_q <= in_if.data;
         tail_vld_q <= push;
      end
      else if (pop)
      begin
         head_q <= in_if.data;
         head_vld_q <= push;
      end
      else if (push && !head_vld_q)
      begin
         head_q <= in_if.data;
         head_vld_q <= 1'b1;
      end
      else if (push)
      begin
         tail_q <= in_if.data;
         tail_vld_q <= 1'b1;
      end
   end
endmodule // rvip_buf

// file: hdl/rvip_pkg.sv
// Constants and types shared by the RGB video input port
package rvip_pkg;
   // Bus and counter widths
   localparam int BUS_W = 18;
   localparam int CNT_W = 8;
   localparam int COL_W = 7;
   localparam int LIN_W = 10;
   localparam int WORD_W = 33;
   // Pixel format codes
   localparam logic [3:0] FMT_16 = 4'h5;
   localparam logic [3:0] FMT_18 = 4'h6;
   localparam logic [3:0] FMT_6 = 4'hE;
   // Mode strap codes
   localparam logic [1:0] MODE_PLAIN = 2'h2;
   localparam logic [1:0] MODE_PORCH = 2'h3;
   // Active area limits and reset values
   localparam logic [7:0] H_LAST = 8'h7F;
   localparam logic [7:0] V_LAST = 8'h9F;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [9:0] LIN_RST = 10'h000;
   // Field positions on the data bus
   localparam int R_HI = 17;
   localparam int R18_LO = 12;
   localparam int R16_LO = 13;
   localparam int G_HI = 11;
   localparam int G_LO = 6;
   localparam int B18_HI = 5;
   localparam int B16_LO = 1;
   localparam int D6_HI = 7;
   localparam int D6_LO = 2;
   // Colour phase of the narrow mode
   typedef enum logic [1:0] {PH_RED, PH_GREEN, PH_BLUE} rvip_phase_e;
endpackage

// file: hdl/rvip_px_if.sv
// Valid/ready carrier for pixel words between the port's modules
`timescale 1ns/1ps
interface rvip_px_if #(parameter int DW = 33);
   logic          valid;
   logic          ready;
   logic [DW-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: hdl/rvip_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module rvip_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage only feeds the second
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // rvip_sync

// file: hdl/rvip_top.sv
// RGB video input port: sync capture, pixel unpack, write counters
//
// How it works
// RL1: Frame sync low starts a new frame.
// RL2: Line sync low starts a new line.
// RL3: Data-valid high marks pixel data.
// RL4: Capture data bus only while data-valid high.
// RL5: Host keeps pixel clock running during use.
// RL6: Pixel clock may stop; never internal clock.
// RL7: Input stays inactive until power-on done.
// RL8: Recover correct image at next frame sync.
// RL9: Write order from mirror straps and bits.
// RL10: Frame sync clears both write counters.
// RL11: Each pixel advances horizontal counter only.
// RL12: Line sync: clear horizontal, advance vertical. Code does this only after a line that took a pixel.
// RL13: Past last pixel both counters return zero.
// RL14: Bus width from four-bit format field.
// RL15: Only three format codes valid here.
// RL16: 18-bit mode: red, green, blue, high first.
// RL17: 16-bit mode: five, six, five bits.
// RL18: 6-bit mode: three transfers on lines 7-2.
// RL19: Host drives unused data lines to levels.
// RL20: Mode 10 writes with host syncs always.
// RL21: Mode 11 applies porch, stores valid data.
// RL22: 16-bit lines: 17-13, 11-6, 5-1.
// RL23: Write pixel at mirrored counter location.
`timescale 1ns/1ps
module rvip_top
   import rvip_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         pclk_in,
   input  wire logic         frame_sync_n_in,
   input  wire logic         line_sync_n_in,
   input  wire logic         pixel_valid_in,
   input  wire logic [17:0]  data_in,
   input  wire logic         column_mirror_pin_in,
   input  wire logic         row_mirror_pin_in,
   input  wire logic         video_mode_sel_hi_in,
   input  wire logic         video_mode_sel_lo_in,
   input  wire logic [3:0]   video_pixel_format_in,
   input  wire logic         column_mirror_in,
   input  wire logic         row_mirror_in,
   input  wire logic [9:0]   porch_vbp_in,
   input  wire logic         power_on_done_in,
   input  wire logic         mem_ready_in,
   output logic              mem_wr_out,
   output logic [6:0]        mem_col_out,
   output logic [7:0]        mem_row_out,
   output logic [17:0]       mem_pixel_out,
   output logic              active_out,
   output logic              format_err_out,
   output logic              timing_err_out,
   output logic              overrun_out
);
   // ****************************************
   // Pin synchronisation
   // ****************************************
   logic [25:0]       pins_s;
   logic [17:0]       data_s;
   logic              pclk_s, vs_n_s, hs_n_s, de_s;
   logic              pclk_prev_q, hs_prev_q;
   logic              rise, frame_clr, line_evt;

   rvip_sync #(.W(26)) u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in ({column_mirror_pin_in, row_mirror_pin_in, video_mode_sel_hi_in,
                  video_mode_sel_lo_in, pclk_in, frame_sync_n_in, line_sync_n_in,
                  pixel_valid_in, data_in}),
      .sync_out (pins_s)
   );

   assign pclk_s = pins_s[21];
   assign vs_n_s = pins_s[20];
   assign hs_n_s = pins_s[19];
   assign de_s = pins_s[18];
   assign data_s = pins_s[17:0];

   // Pixel clock edge finder; nothing runs off the pixel clock itself
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         pclk_prev_q <= 1'b0;
         hs_prev_q <= 1'b1;
      end
      else
      begin
         pclk_prev_q <= pclk_s;                 // RL6
         if (rise)
            hs_prev_q <= hs_n_s;
      end
   end

   assign rise = pclk_s & ~pclk_prev_q;         // RL6
   assign frame_clr = rise & ~vs_n_s;           // RL1
   assign line_evt = rise & ~hs_n_s & hs_prev_q; // RL2

   // ****************************************
   // Straps, format and enable
   // ****************************************
   logic [1:0]        mode_q, strap_fill_q;
   logic              strap_taken_q, cmir_pin_q, rmir_pin_q;
   logic              fmt_valid, active_q, fmt_err_q;

   // Straps caught once the synchroniser holds real pin levels, three edges after release
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         strap_fill_q <= 2'h0;
         strap_taken_q <= 1'b0;
         cmir_pin_q <= 1'b0;
         rmir_pin_q <= 1'b0;
         mode_q <= 2'h0;
      end
      else if (!strap_taken_q)
      begin
         strap_fill_q <= {strap_fill_q[0], 1'b1};
         strap_taken_q <= strap_fill_q[1];      // Last capture is the valid one
         cmir_pin_q <= pins_s[25];              // RL9
         rmir_pin_q <= pins_s[24];
         mode_q <= pins_s[23:22];
      end
   end

   assign fmt_valid = (video_pixel_format_in == FMT_16) || // RL14
                      (video_pixel_format_in == FMT_18) ||
                      (video_pixel_format_in == FMT_6);    // RL15

   // Port runs only after power-on with a valid mode and format
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         active_q <= 1'b0;
         fmt_err_q <= 1'b0;
      end
      else
      begin
         active_q <= strap_taken_q & power_on_done_in & fmt_valid // RL7
                     & mode_q[1];                                 // RL20
         fmt_err_q <= ~fmt_valid;                                 // RL15
      end
   end

   // ****************************************
   // Frame state and write counters
   // ****************************************
   logic [7:0]        h_q, v_q;
   logic [9:0]        line_idx_q;
   logic              line_pix_q, frame_ok_q, terr_q;
   logic              lines_ok, take, pix_done;
   rvip_phase_e       phase_q;

   // Porch mode skips lines before the back porch count
   assign lines_ok = (mode_q != MODE_PORCH) || (line_idx_q >= porch_vbp_in); // RL21
   assign take = rise & de_s & vs_n_s & active_q & frame_ok_q & lines_ok; // RL3 RL4
   assign pix_done = take & ((video_pixel_format_in != FMT_6) || (phase_q == PH_BLUE));

   // Counter update; frame sync overrides everything
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         h_q <= CNT_RST;
         v_q <= CNT_RST;
         line_idx_q <= LIN_RST;
         line_pix_q <= 1'b0;
      end
      else if (frame_clr)
      begin
         h_q <= CNT_RST;                        // RL10
         v_q <= CNT_RST;
         line_idx_q <= LIN_RST;
         line_pix_q <= 1'b0;
      end
      else if (line_evt)
      begin
         line_idx_q <= line_idx_q + 10'h001;
         if (line_pix_q)
         begin
            h_q <= CNT_RST;                     // RL12
            v_q <= v_q + 8'h01;
         end
         line_pix_q <= 1'b0;
      end
      else if (pix_done && h_q <= H_LAST)
      begin
         line_pix_q <= 1'b1;
         if (h_q == H_LAST && v_q == V_LAST)
         begin
            h_q <= CNT_RST;                     // RL13
            v_q <= CNT_RST;
         end
         else
            h_q <= h_q + 8'h01;                 // RL11
      end
   end

   // Bad timing stops writes until the next frame sync
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         frame_ok_q <= 1'b0;
         terr_q <= 1'b0;
      end
      else if (!active_q)
         frame_ok_q <= 1'b0;
      else if (frame_clr)
      begin
         frame_ok_q <= 1'b1;                    // RL8
         terr_q <= 1'b0;
      end
      else if ((pix_done && h_q > H_LAST) || (line_evt && line_pix_q && v_q >= V_LAST))
      begin
         frame_ok_q <= 1'b0;                    // RL8
         terr_q <= 1'b1;
      end
   end

   // ****************************************
   // Pixel unpacking
   // ****************************************
   logic [5:0]        red_q, green_q;
   logic [17:0]       pixel;
   logic              cmir, rmir;
   logic [6:0]        col;
   logic [7:0]        row;

   // Narrow mode colour phase, restarted by any sync
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         phase_q <= PH_RED;
         red_q <= 6'h00;
         green_q <= 6'h00;
      end
      else if (frame_clr || line_evt)
         phase_q <= PH_RED;
      else if (take && video_pixel_format_in == FMT_6)
      begin
         case (phase_q)                         // RL18
            PH_RED:
            begin
               red_q <= data_s[D6_HI:D6_LO];
               phase_q <= PH_GREEN;
            end
            PH_GREEN:
            begin
               green_q <= data_s[D6_HI:D6_LO];
               phase_q <= PH_BLUE;
            end
            default:
               phase_q <= PH_RED;
         endcase
      end
   end

   // Pixel word in red-green-blue 6-6-6 form
   always_comb
   begin
      case (video_pixel_format_in)
         FMT_16:                                // RL17 RL22
            pixel = {data_s[R_HI:R16_LO], data_s[R_HI], data_s[G_HI:G_LO],
                     data_s[B18_HI:B16_LO], data_s[B18_HI]};
         FMT_6:
            pixel = {red_q, green_q, data_s[D6_HI:D6_LO]}; // RL18
         default:
            pixel = data_s;                     // RL16
      endcase
   end

   // Mirrored write location
   assign cmir = column_mirror_in ^ cmir_pin_q; // RL9
   assign rmir = row_mirror_in ^ rmir_pin_q;
   assign col = cmir ? (H_LAST[6:0] - h_q[6:0]) : h_q[6:0]; // RL23
   assign row = rmir ? (V_LAST - v_q) : v_q;

   // ****************************************
   // Write path through the buffer
   // ****************************************
   rvip_px_if #(.DW(WORD_W)) wr_if ();
   rvip_px_if #(.DW(WORD_W)) mem_if ();
   logic              wr_q, ovr_q;
   logic [WORD_W-1:0] wr_data_q;

   // Offer each finished pixel; a full buffer drops it
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         wr_q <= 1'b0;
         wr_data_q <= '0;
         ovr_q <= 1'b0;
      end
      else
      begin
         wr_q <= pix_done && (h_q <= H_LAST) && !frame_clr && !line_evt; // RL4
         wr_data_q <= {row, col, pixel};        // RL23
         if (wr_q && !wr_if.ready)
            ovr_q <= 1'b1;
         else if (frame_clr)
            ovr_q <= 1'b0;
      end
   end

   assign wr_if.valid = wr_q;
   assign wr_if.data = wr_data_q;
   assign mem_if.ready = mem_ready_in;

   rvip_buf u_buf (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .in_if    (wr_if),
      .out_if   (mem_if)
   );

   // Outputs, all from flip-flops
   assign mem_wr_out = mem_if.valid;
   assign mem_row_out = mem_if.data[32:25];
   assign mem_col_out = mem_if.data[24:18];
   assign mem_pixel_out = mem_if.data[17:0];
   assign active_out = active_q;
   assign format_err_out = fmt_err_q;
   assign timing_err_out = terr_q;
   assign overrun_out = ovr_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   AST_FMT_BAD: assert property (!fmt_valid |=> !active_q && fmt_err_q) // RL15
      else $error("invalid format left port active");
   AST_POWER: assert property (!power_on_done_in |=> !active_q) // RL7
      else $error("port active before power-on done");
   AST_NO_DE: assert property (rise && !de_s |=> !wr_q) // RL4
      else $error("write without data-valid");
   AST_FRAME: assert property (frame_clr |=> h_q == 8'h00 && v_q == 8'h00) // RL10
      else $error("frame sync did not clear counters");
   AST_HSTEP: assert property (h_q != $past(h_q) && h_q != 8'h00
                               |-> h_q == $past(h_q) + 8'h01 && v_q == $past(v_q)) // RL11
      else $error("horizontal counter stepped wrongly");
   AST_LINE: assert property (line_evt && line_pix_q && !frame_clr
                              |=> h_q == 8'h00 && v_q == $past(v_q) + 8'h01) // RL12
      else $error("line sync did not advance vertical counter");
   AST_WRAP: assert property (pix_done && h_q == H_LAST && v_q == V_LAST && !frame_clr
                              && !line_evt |=> h_q == 8'h00 && v_q == 8'h00) // RL13
      else $error("counters did not wrap at end of area");
   AST_RECOVER: assert property (frame_clr && active_q ##1 active_q |-> frame_ok_q) // RL8
      else $error("no recovery at frame sync");
   AST_MAP16: assert property (wr_q && video_pixel_format_in == FMT_16
                               && $stable(video_pixel_format_in)
                               |-> wr_data_q[17:13] == $past(data_s[17:13])) // RL17
      else $error("16-bit red field misplaced");
   AST_MIRROR: assert property (wr_q && !$past(cmir)
                                |-> wr_data_q[24:18] == $past(h_q[6:0])) // RL9
      else $error("column written at wrong place");

   COV_WRAP: cover property (pix_done && h_q == H_LAST && v_q == V_LAST);
   COV_NARROW: cover property (wr_q && video_pixel_format_in == FMT_6);
   COV_OVERRUN: cover property (wr_q && !wr_if.ready);
endmodule // rvip_top

// file: tb/rvip_host.sv
// Behavioural display host that drives the pixel pins of the port
`timescale 1ns/1ps
module rvip_host
   import rvip_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic [3:0]       format_in,
   output logic                  pclk_out,
   output logic                  frame_sync_n_out,
   output logic                  line_sync_n_out,
   output logic                  pixel_valid_out,
   output logic [BUS_W-1:0]      data_out
);
   logic [BUS_W-1:0] tx_q[$];
   logic [BUS_W-1:0] last_q;

   // Idle pins at time zero; the pixel clock stands still outside frames
   initial
   begin
      pclk_out = 1'b0;
      frame_sync_n_out = 1'b1;
      line_sync_n_out = 1'b1;
      pixel_valid_out = 1'b0;
      last_q = 18'h00000;
      data_out = 18'h00000;
   end

   // One pixel clock period of eight system clocks; pins move at its fall
   task automatic cyc(input logic fs, input logic ls, input logic dv);
      begin
         @(negedge clk_in);
         pclk_out = 1'b0;
         frame_sync_n_out = fs;
         line_sync_n_out = ls;
         pixel_valid_out = dv;
         if (dv)
            last_q = tx_q.pop_front();
         data_out = dv ? last_q : ~last_q;
         repeat (4) @(negedge clk_in);
         pclk_out = 1'b1;
         repeat (3) @(negedge clk_in);
      end
   endtask

   // Frame sync low for two pixel clocks, then released
   task automatic fsync();
      begin
         cyc(1'b0, 1'b1, 1'b0);
         cyc(1'b0, 1'b1, 1'b0);
         cyc(1'b1, 1'b1, 1'b0);
      end
   endtask

   // Line sync pulse, porch, n pixels (three transfers in narrow mode), porch
   task automatic line(input int n);
      int k;
      begin
         k = (format_in == FMT_6) ? 3 * n : n;
         cyc(1'b1, 1'b0, 1'b0);
         cyc(1'b1, 1'b1, 1'b0);
         repeat (k) cyc(1'b1, 1'b1, 1'b1);
         cyc(1'b1, 1'b1, 1'b0);
         cyc(1'b1, 1'b1, 1'b0);
      end
   endtask
endmodule // rvip_host

// file: tb/rvip_top_tb.sv
// Self-checking bench for the RGB video input port
`timescale 1ns/1ps
module rvip_top_tb
   import rvip_pkg::*;
   ;
   // ****************************
   // Signals and model state
   // ****************************
   logic              clk_in, reset_in, pclk, fs_n, ls_n, dv, pwr, mx, my;
   logic              mem_ready, mem_wr, active, fmt_err, t_err, ovr, stall, chk_en;
   logic              column_mirror_pin, row_mirror_pin, mlo;
   logic [9:0]        vbp;
   logic [BUS_W-1:0]  data, pix;
   logic [3:0]        fmt;
   logic [6:0]        col;
   logic [7:0]        row;
   logic [WORD_W-1:0] exp_q[$];
   logic [3:0]        fmts[3] = '{FMT_18, FMT_16, FMT_6};
   int                fail_count, samples_checked, h, v, i, k, ln;
   bit                had_pix, terr;

   rvip_top i_dut (
      .clk_in(clk_in), .reset_in(reset_in), .pclk_in(pclk),
      .frame_sync_n_in(fs_n), .line_sync_n_in(ls_n),
      .pixel_valid_in(dv), .data_in(data),
      .column_mirror_pin_in(column_mirror_pin), .row_mirror_pin_in(row_mirror_pin),
      .video_mode_sel_hi_in(1'b1), .video_mode_sel_lo_in(mlo),
      .video_pixel_format_in(fmt), .column_mirror_in(mx),
      .row_mirror_in(my), .porch_vbp_in(vbp),
      .power_on_done_in(pwr), .mem_ready_in(mem_ready),
      .mem_wr_out(mem_wr), .mem_col_out(col), .mem_row_out(row),
      .mem_pixel_out(pix), .active_out(active), .format_err_out(fmt_err),
      .timing_err_out(t_err), .overrun_out(ovr)
   );

   rvip_host i_host (
      .clk_in(clk_in), .format_in(fmt), .pclk_out(pclk),
      .frame_sync_n_out(fs_n), .line_sync_n_out(ls_n),
      .pixel_valid_out(dv), .data_out(data)
   );

   // System clock, 4 ns period
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // Memory side accepts at random, or never while stalled
   always @(negedge clk_in)
      mem_ready <= !stall && ($urandom % 4 != 0);

   // Every accepted write while chk_en is set is compared with the model
   always @(posedge clk_in)
      if (!reset_in && mem_wr && mem_ready && chk_en)
      begin
         samples_checked++;
         if (exp_q.size() == 0)
            bad("write with nothing expected");
         else if ({col, row, pix} !== exp_q.pop_front())
            bad("write word differs");
      end

   // ****************************
   // Tasks
   // ****************************
   task automatic bad(input string m);
      begin
         $display("BAD %0t %s", $time, m);
         fail_count++;
      end
   endtask

   task automatic chk(input logic got, input logic want, input string m);
      begin
         samples_checked++;
         if (got !== want)
            bad(m);
      end
   endtask

   // Frame start resets the model counters
   task automatic tx_frame();
      begin
         h = 0;
         v = 0;
         had_pix = 1'b0;
         ln = 0;
         terr = 1'b0;
         i_host.fsync();
      end
   endtask

   // One line of n random pixels; expected words follow the counter rules
   task automatic tx_line(input int n);
      logic [BUS_W-1:0] a, b, c, p;
      bit               skip;
      begin
         ln++;
         skip = mlo && (ln < vbp);
         if (had_pix)
         begin
            h = 0;
            v++;
         end
         had_pix = (n > 0) && !skip;
         repeat (n)
         begin
            a = 18'($urandom);
            b = 18'($urandom);
            c = 18'($urandom);
            i_host.tx_q.push_back(a);
            if (fmt == FMT_6)
            begin
               i_host.tx_q.push_back(b);
               i_host.tx_q.push_back(c);
            end
            p = (fmt == FMT_16) ? {a[17:13], a[17], a[11:6], a[5:1], a[5]} :
                (fmt == FMT_6) ? {a[7:2], b[7:2], c[7:2]} : a;
            if (h > 127)
               terr = 1'b1;
            if (!terr && !skip)
               exp_q.push_back({(mx ^ column_mirror_pin) ? 7'(127 - h) : 7'(h),
                                (my ^ row_mirror_pin) ? 8'(159 - v) : 8'(v), p});
            if (h == 127 && v == 159)
            begin
               h = 0;
               v = 0;
            end
            else if (!skip)
               h++;
         end
         i_host.line(n);
      end
   endtask

   // Bounded wait until every expected word was written
   task automatic drain();
      int t;
      begin
         for (t = 0; t < 4000 && exp_q.size() != 0; t++)
            @(posedge clk_in);
         if (exp_q.size() != 0)
         begin
            bad("words missing");
            stop_test();
         end
         repeat (8) @(negedge clk_in);
      end
   endtask

   task automatic stop_test();
      begin
         $display("Checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // Hang guard
   initial
   begin
      #400000;
      bad("run timeout");
      stop_test();
   end

   // ****************************
   // Main sequence
   // ****************************
   initial
   begin
      void'($urandom(32'h1EE53BF6));
      reset_in = 1'b1;
      {pwr, mx, my, stall, mem_ready, column_mirror_pin, row_mirror_pin, mlo} = 8'h00;
      vbp = 10'h000;
      chk_en = 1'b1;
      fmt = FMT_18;
      repeat (20) @(negedge clk_in);
      reset_in = 1'b0;
      // Port stays off until power-on completes
      repeat (6) @(negedge clk_in);
      chk(active, 1'b0, "active before power-on");
      tx_frame();
      terr = 1'b1;
      tx_line(4);
      drain();
      pwr = 1'b1;
      repeat (6) @(negedge clk_in);
      chk(active, 1'b1, "port not active");
      // Every format code, pixel clock standing still
      for (i = 0; i < 16; i++)
      begin
         fmt = 4'(i);
         repeat (3) @(negedge clk_in);
         chk(fmt_err, !(fmt inside {FMT_16, FMT_18, FMT_6}), "format flag");
      end
      fmt = FMT_18;
      repeat (6) @(negedge clk_in);
      // Formats cycled over six frames that cover all four mirror settings
      for (k = 0; k < 6; k++)
      begin
         fmt = fmts[k % 3];
         mx = k[0];
         my = k[1];
         tx_frame();
         repeat (4) tx_line(int'($urandom % 6));
         drain();
      end
      // Over-long line, then recovery at the next frame
      {mx, my} = 2'h0;
      fmt = FMT_18;
      tx_frame();
      tx_line(130);
      tx_line(3);
      drain();
      chk(t_err, 1'b1, "no timing error");
      tx_frame();
      repeat (8) @(negedge clk_in);
      chk(t_err, 1'b0, "timing error kept");
      tx_line(4);
      drain();
      // Last pixel of the area wraps both counters
      tx_frame();
      repeat (159) tx_line(1);
      tx_line(129);
      drain();
      // Receiver stalls through a line: words dropped and flagged
      stall = 1'b1;
      chk_en = 1'b0;
      tx_frame();
      tx_line(20);
      chk(ovr, 1'b1, "no overrun");
      stall = 1'b0;
      repeat (50) @(negedge clk_in);
      exp_q.delete();
      chk_en = 1'b1;
      tx_frame();
      repeat (8) @(negedge clk_in);
      chk(ovr, 1'b0, "overrun kept");
      tx_line(5);
      drain();
      // Reset mid-run with both mirror straps and porch mode: first line skipped
      reset_in = 1'b1;
      {column_mirror_pin, row_mirror_pin, mlo} = 3'h7;
      vbp = 10'h002;
      repeat (20) @(negedge clk_in);
      reset_in = 1'b0;
      repeat (8) @(negedge clk_in);
      chk(active, 1'b1, "port off after reset");
      for (k = 0; k < 3; k++)
      begin
         fmt = fmts[k];
         tx_frame();
         repeat (4) tx_line(int'($urandom % 4) + 1);
         drain();
      end
      stop_test();
   end
endmodule // rvip_top_tb
